// ### rtl/ctr_pwm_pkg.sv
// Constants, register map and state types for the counter/PWM command unit
package ctr_pwm_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ADDR_CTR_CMD = 8'h00;
  localparam logic [7:0] ADDR_PWM_CMD = 8'h04;
  localparam logic [7:0] ADDR_DATA    = 8'h08;
  localparam logic [7:0] ADDR_LATCH0  = 8'h0c;
  localparam logic [7:0] ADDR_LATCH1  = 8'h10;
  localparam logic [7:0] ADDR_STATUS  = 8'h14;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  // Command word fields
  localparam int unsigned CMD_CODE_LSB = 0;
  localparam int unsigned CMD_OPT_LSB  = 4;
  localparam int unsigned CMD_SEL_LSB  = 8;
  // Status fields
  localparam int unsigned ST_CTR_RUN   = 0;
  localparam int unsigned ST_LATCH_PND = 4;
  localparam int unsigned ST_PWM_RUN   = 8;
  // Counter command codes
  localparam logic [3:0] CC_CLEAR  = 4'h0;
  localparam logic [3:0] CC_LOAD   = 4'h1;
  localparam logic [3:0] CC_DIR    = 4'h2;
  localparam logic [3:0] CC_GATE   = 4'h3;
  localparam logic [3:0] CC_ENABLE = 4'h4;
  localparam logic [3:0] CC_LATCH  = 4'h5;
  localparam logic [3:0] CC_CLKSRC = 4'h6;
  localparam logic [3:0] CC_AUTORL = 4'h7;
  localparam logic [3:0] CC_OUTPUT = 4'h8;
  localparam logic [3:0] CC_RESET  = 4'hf;
  localparam logic [7:0] SEL_ALL   = 8'hff;
  // Counter clock options
  localparam logic [1:0] CLK_EXT  = 2'h0;
  localparam logic [1:0] CLK_F50  = 2'h2;
  localparam logic [1:0] CLK_F1   = 2'h3;
  // PWM command codes
  localparam logic [3:0] PC_STOP   = 4'h0;
  localparam logic [3:0] PC_LOAD   = 4'h1;
  localparam logic [3:0] PC_POL    = 4'h2;
  localparam logic [3:0] PC_PULSE  = 4'h3;
  localparam logic [3:0] PC_RESET  = 4'h4;
  localparam logic [3:0] PC_ROUTE  = 4'h5;
  localparam logic [3:0] PC_CLKSRC = 4'h6;
  localparam logic [3:0] PC_START  = 4'h7;
  // Port F bit of counter 0; counter 1 sits one above
  localparam int unsigned CTR_PIN_BASE = 2;
  // Timing
  localparam int unsigned CLK_HZ  = 50_000_000;
  localparam int unsigned SLOW_HZ = 1_000_000;
  localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_HZ;
  localparam logic [5:0] SLOW_LAST = 6'(SLOW_DIV - 1);

  typedef struct packed {
    logic [31:0] count;
    logic [31:0] reload;
    logic [31:0] latched;
    logic [1:0]  clk_sel;
    logic        down;
    logic        gate_en;
    logic        run;
    logic        auto_rl;
    logic        out_en;
    logic        out_pol;
    logic        latch_pend;
    logic        ext_q;
  } ctr_t;

  typedef struct packed {
    logic [31:0] period;
    logic [31:0] duty;
    logic [31:0] pcnt;
    logic [31:0] dcnt;
    logic        pol;
    logic        pulse_en;
    logic        route_en;
    logic        slow;
    logic        run;
  } pwm_t;

  typedef struct packed {
    logic [3:0] own;
    logic [3:0] oe;
    logic [3:0] out;
  } dio_ovr_t;

  typedef struct packed {
    ctr_t [1:0]  ctr;
    pwm_t [3:0]  pwm;
    logic [31:0] data;
    logic [5:0]  div;
    logic        slow_tick;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    dio_ovr_t    dio;
  } state_t;
endpackage

// ### rtl/ctr_pwm_unit.sv
// Counter/timer and PWM command unit with AXI4-Lite register access
`timescale 1ns/1ns
`default_nettype none
module ctr_pwm_unit
  import ctr_pwm_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // AXI4-Lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Port F pins and counter gates
  input  wire logic [3:0]        dio_in,
  input  wire logic [1:0]        ext_gate,
  output dio_ovr_t               dio_ovr
);

  state_t      st_ff;
  state_t      nxt_st;
  logic        exec_ctr;
  logic        exec_pwm;
  logic [3:0]  cmd_code;
  logic [3:0]  cmd_opt;
  logic [7:0]  cmd_sel;
  logic [1:0]  ctr_tick;
  logic [1:0]  ctr_reloading;
  logic [3:0]  pwm_lvl;

  function automatic logic addr_ok(input logic [7:0] a);
    return a inside {ADDR_CTR_CMD, ADDR_PWM_CMD, ADDR_DATA, ADDR_LATCH0, ADDR_LATCH1,
                     ADDR_STATUS};
  endfunction

  function automatic logic clk_tick(input logic [1:0] sel, input logic fall,
                                    input logic slow);
    logic t;
    t = 1'b0;
    if (sel == CLK_EXT)
    begin
      t = fall;
    end
    else if (sel == CLK_F50)
    begin
      t = 1'b1;
    end
    else if (sel == CLK_F1)
    begin
      t = slow;
    end
    return t;
  endfunction

  assign awready = !st_ff.aw_got && !st_ff.bvalid;
  assign wready  = !st_ff.w_got && !st_ff.bvalid;
  assign arready = !st_ff.rvalid;
  assign bvalid  = st_ff.bvalid;
  assign bresp   = st_ff.bresp;
  assign rvalid  = st_ff.rvalid;
  assign rdata   = st_ff.rdata;
  assign rresp   = st_ff.rresp;
  assign dio_ovr = st_ff.dio;

  always_comb
  begin
    nxt_st = st_ff;
    // Command decode: taken once both halves of a write are held
    exec_ctr = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid && st_ff.wstrb[0]
               && st_ff.waddr == ADDR_CTR_CMD;
    exec_pwm = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid && st_ff.wstrb[0]
               && st_ff.waddr == ADDR_PWM_CMD;
    cmd_code = st_ff.wdata[CMD_CODE_LSB +: 4];
    cmd_opt  = st_ff.wdata[CMD_OPT_LSB +: 4];
    cmd_sel  = st_ff.wdata[CMD_SEL_LSB +: 8];

    // 1 MHz tick from the 50 MHz clock
    nxt_st.slow_tick = (st_ff.div == SLOW_LAST);
    nxt_st.div = (st_ff.div == SLOW_LAST) ? 6'h00 : st_ff.div + 6'h01;

    // Write channel
    if (awvalid && awready)
    begin
      nxt_st.aw_got = 1'b1;
      nxt_st.waddr  = awaddr;
    end
    if (wvalid && wready)
    begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = wdata;
      nxt_st.wstrb = wstrb;
    end
    if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid)
    begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = addr_ok(st_ff.waddr) ? RESP_OKAY : RESP_SLVERR;
      if (st_ff.waddr == ADDR_DATA)
      begin
        for (int b = 0; b < 4; b++)
        begin
          if (st_ff.wstrb[b])
          begin
            nxt_st.data[8*b +: 8] = st_ff.wdata[8*b +: 8];
          end
        end
      end
    end
    if (st_ff.bvalid && bready)
    begin
      nxt_st.bvalid = 1'b0;
    end

    // Read channel
    if (arvalid && arready)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
      nxt_st.rdata  = 32'h0000_0000;
      unique case (araddr)
        ADDR_DATA:   nxt_st.rdata = st_ff.data;
        ADDR_LATCH0: nxt_st.rdata = st_ff.ctr[0].latched;
        ADDR_LATCH1: nxt_st.rdata = st_ff.ctr[1].latched;
        ADDR_STATUS:
        begin
          for (int i = 0; i < 2; i++)
          begin
            nxt_st.rdata[ST_CTR_RUN + i]   = st_ff.ctr[i].run;
            nxt_st.rdata[ST_LATCH_PND + i] = st_ff.ctr[i].latch_pend;
          end
          for (int p = 0; p < 4; p++)
          begin
            nxt_st.rdata[ST_PWM_RUN + p] = st_ff.pwm[p].run;
          end
        end
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
    else if (st_ff.rvalid && rready)
    begin
      nxt_st.rvalid = 1'b0;
    end

    // Counters
    for (int i = 0; i < 2; i++)
    begin
      nxt_st.ctr[i].ext_q = dio_in[CTR_PIN_BASE + i];
      // External clock is active low: count on the falling edge
      ctr_tick[i] = clk_tick(st_ff.ctr[i].clk_sel,
                             st_ff.ctr[i].ext_q && !dio_in[CTR_PIN_BASE + i],
                             st_ff.slow_tick)
                    && (!st_ff.ctr[i].gate_en || ext_gate[i]);
      ctr_reloading[i] = st_ff.ctr[i].run && st_ff.ctr[i].down && st_ff.ctr[i].auto_rl
                         && st_ff.ctr[i].count == 32'h0000_0001;
      if (st_ff.ctr[i].run && ctr_tick[i])
      begin
        if (!st_ff.ctr[i].down)
        begin
          nxt_st.ctr[i].count = st_ff.ctr[i].count + 32'h0000_0001;
        end
        else if (st_ff.ctr[i].count == 32'h0000_0001 && st_ff.ctr[i].auto_rl)
        begin
          nxt_st.ctr[i].count = st_ff.ctr[i].reload;
        end
        else if (st_ff.ctr[i].count <= 32'h0000_0001)
        begin
          nxt_st.ctr[i].count = 32'h0000_0000;
          nxt_st.ctr[i].run   = 1'b0;
        end
        else
        begin
          nxt_st.ctr[i].count = st_ff.ctr[i].count - 32'h0000_0001;
        end
      end
      // Deferred latch
      if (st_ff.ctr[i].latch_pend && !ctr_reloading[i])
      begin
        nxt_st.ctr[i].latched    = st_ff.ctr[i].count;
        nxt_st.ctr[i].latch_pend = 1'b0;
      end
      if (exec_ctr && (cmd_sel == 8'(i) || (cmd_code == CC_RESET && cmd_sel == SEL_ALL)))
      begin
        unique case (cmd_code)
          CC_CLEAR:  nxt_st.ctr[i].count = st_ff.ctr[i].down ? st_ff.ctr[i].reload
                                                              : 32'h0000_0000;
          CC_LOAD:
          begin
            nxt_st.ctr[i].reload = st_ff.data;
            nxt_st.ctr[i].count  = st_ff.data;
          end
          CC_DIR:    nxt_st.ctr[i].down    = cmd_opt[0];
          CC_GATE:   nxt_st.ctr[i].gate_en = cmd_opt[0];
          CC_ENABLE: nxt_st.ctr[i].run     = cmd_opt[0];
          CC_LATCH:  nxt_st.ctr[i].latch_pend = 1'b1;
          CC_CLKSRC: nxt_st.ctr[i].clk_sel = cmd_opt[1:0];
          CC_AUTORL: nxt_st.ctr[i].auto_rl = cmd_opt[0];
          CC_OUTPUT:
          begin
            nxt_st.ctr[i].out_en  = 1'b1;
            nxt_st.ctr[i].out_pol = cmd_opt[0];
          end
          CC_RESET:  nxt_st.ctr[i] = '0;
          default: ;
        endcase
      end
    end

    // PWMs
    for (int p = 0; p < 4; p++)
    begin
      pwm_lvl[p] = (st_ff.pwm[p].pulse_en && st_ff.pwm[p].run
                    && st_ff.pwm[p].dcnt != 32'h0000_0000)
                   ? !st_ff.pwm[p].pol : st_ff.pwm[p].pol;
      if (st_ff.pwm[p].run && (!st_ff.pwm[p].slow || st_ff.slow_tick))
      begin
        if (st_ff.pwm[p].pcnt <= 32'h0000_0001)
        begin
          nxt_st.pwm[p].pcnt = st_ff.pwm[p].period;
          nxt_st.pwm[p].dcnt = st_ff.pwm[p].duty;
        end
        else
        begin
          nxt_st.pwm[p].pcnt = st_ff.pwm[p].pcnt - 32'h0000_0001;
          if (st_ff.pwm[p].dcnt != 32'h0000_0000)
          begin
            nxt_st.pwm[p].dcnt = st_ff.pwm[p].dcnt - 32'h0000_0001;
          end
        end
      end
      if (exec_pwm)
      begin
        unique case (cmd_code)
          PC_STOP:
          begin
            if (!cmd_opt[0] || cmd_sel[1:0] == 2'(p))
            begin
              nxt_st.pwm[p].run  = 1'b0;
              nxt_st.pwm[p].pcnt = st_ff.pwm[p].period;
              nxt_st.pwm[p].dcnt = st_ff.pwm[p].duty;
            end
          end
          PC_LOAD:
          begin
            if (cmd_sel[1:0] == 2'(p))
            begin
              if (cmd_opt[0])
              begin
                nxt_st.pwm[p].duty = st_ff.data;
              end
              else
              begin
                nxt_st.pwm[p].period = st_ff.data;
              end
            end
          end
          PC_POL:    if (cmd_sel[1:0] == 2'(p)) nxt_st.pwm[p].pol = cmd_opt[0];
          PC_PULSE:  if (cmd_sel[1:0] == 2'(p)) nxt_st.pwm[p].pulse_en = cmd_opt[0];
          PC_RESET:  if (cmd_opt[0] || cmd_sel[1:0] == 2'(p)) nxt_st.pwm[p] = '0;
          PC_ROUTE:  if (cmd_sel[1:0] == 2'(p)) nxt_st.pwm[p].route_en = cmd_opt[0];
          PC_CLKSRC: if (cmd_sel[1:0] == 2'(p)) nxt_st.pwm[p].slow = cmd_opt[0];
          PC_START:
          begin
            if ((cmd_opt[0] || cmd_sel[1:0] == 2'(p)) && !st_ff.pwm[p].run)
            begin
              nxt_st.pwm[p].run  = 1'b1;
              nxt_st.pwm[p].pcnt = st_ff.pwm[p].period;
              nxt_st.pwm[p].dcnt = st_ff.pwm[p].duty;
            end
          end
          default: ;
        endcase
      end
      // Pin override: PWM first, counters take bits 2 and 3 over it
      nxt_st.dio.own[p] = st_ff.pwm[p].route_en;
      nxt_st.dio.oe[p]  = st_ff.pwm[p].route_en;
      nxt_st.dio.out[p] = st_ff.pwm[p].route_en && pwm_lvl[p];
    end
    for (int i = 0; i < 2; i++)
    begin
      if (st_ff.ctr[i].run && st_ff.ctr[i].clk_sel == CLK_EXT)
      begin
        nxt_st.dio.own[CTR_PIN_BASE + i] = 1'b1;
        nxt_st.dio.oe[CTR_PIN_BASE + i]  = 1'b0;
        nxt_st.dio.out[CTR_PIN_BASE + i] = 1'b0;
      end
      else if (st_ff.ctr[i].out_en)
      begin
        nxt_st.dio.own[CTR_PIN_BASE + i] = 1'b1;
        nxt_st.dio.oe[CTR_PIN_BASE + i]  = 1'b1;
        // Pulse is the last count of each down period
        nxt_st.dio.out[CTR_PIN_BASE + i] =
          (st_ff.ctr[i].run && st_ff.ctr[i].down && st_ff.ctr[i].count == 32'h0000_0001)
          ? !st_ff.ctr[i].out_pol : st_ff.ctr[i].out_pol;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_wr_resp;
    st_ff.aw_got && st_ff.w_got && !st_ff.bvalid |=> bvalid ##0 !st_ff.aw_got;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response missing");

  property p_clear_up;
    exec_ctr && cmd_code == CC_CLEAR && cmd_sel == 8'h01 && !st_ff.ctr[1].down
    |=> st_ff.ctr[1].count == 32'h0000_0000;
  endproperty
  a_clear_up: assert property (p_clear_up) else $error("clear left count nonzero");

  property p_load;
    exec_ctr && cmd_code == CC_LOAD && cmd_sel == 8'h01
    |=> st_ff.ctr[1].count == $past(st_ff.data) && st_ff.ctr[1].reload == $past(st_ff.data);
  endproperty
  a_load: assert property (p_load) else $error("load value wrong");

  property p_stop_at_zero;
    !exec_ctr && ctr_tick[0] && st_ff.ctr[0].run && st_ff.ctr[0].down
    && !st_ff.ctr[0].auto_rl && st_ff.ctr[0].count == 32'h0000_0001
    |=> st_ff.ctr[0].count == 32'h0000_0000 && !st_ff.ctr[0].run;
  endproperty
  a_stop_at_zero: assert property (p_stop_at_zero) else $error("count did not stop");

  property p_latch_wait;
    st_ff.ctr[0].latch_pend && ctr_reloading[0]
    |=> st_ff.ctr[0].latch_pend || $past(exec_ctr);
  endproperty
  a_latch_wait: assert property (p_latch_wait) else $error("latch taken in reload");

  property p_reset_all;
    exec_ctr && cmd_code == CC_RESET && cmd_sel == SEL_ALL
    |=> !st_ff.ctr[0].run && !st_ff.ctr[1].out_en ##1 !dio_ovr.own[2] && !dio_ovr.own[3];
  endproperty
  a_reset_all: assert property (p_reset_all) else $error("reset kept pins");

  property p_input_wins;
    st_ff.ctr[1].run && st_ff.ctr[1].clk_sel == CLK_EXT && st_ff.ctr[1].out_en
    |=> dio_ovr.own[3] && !dio_ovr.oe[3];
  endproperty
  a_input_wins: assert property (p_input_wins) else $error("output beat input");

  property p_pwm_stop_all;
    exec_pwm && cmd_code == PC_STOP && !cmd_opt[0]
    |=> !st_ff.pwm[0].run && !st_ff.pwm[3].run ##1 pwm_lvl[0] == st_ff.pwm[0].pol;
  endproperty
  a_pwm_stop_all: assert property (p_pwm_stop_all) else $error("pwm not stopped");

  property p_pwm_level;
    st_ff.pwm[0].route_en && !exec_pwm && st_ff.pwm[0].run && st_ff.pwm[0].pulse_en
    && st_ff.pwm[0].dcnt != 32'h0000_0000 |=> dio_ovr.out[0] == !$past(st_ff.pwm[0].pol);
  endproperty
  a_pwm_level: assert property (p_pwm_level) else $error("pwm level wrong");

endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking testbench for the counter/PWM command unit
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import ctr_pwm_pkg::*;
  logic        aclk;
  logic        aresetn;
  logic        awvalid;
  logic        wvalid;
  logic        bready;
  logic        arvalid;
  logic        rready;
  logic        awready;
  logic        wready;
  logic        bvalid;
  logic        arready;
  logic        rvalid;
  logic [7:0]  awaddr;
  logic [7:0]  araddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0]  wstrb;
  logic [3:0]  dio_in;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [1:0]  ext_gate;
  dio_ovr_t    dio_ovr;
  int          err_count;
  int          checks;
  int          k;
  logic [15:0] lfsr;
  logic [31:0] v;
  logic [31:0] n;
  logic [31:0] d;
  logic [1:0]  r;

  ctr_pwm_unit uut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .dio_in(dio_in), .ext_gate(ext_gate), .dio_ovr(dio_ovr)
  );

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tmo;
    err_count++;
    $display("[ERR] %0t bus wait ran out", $time);
    end_sim();
  endtask

  // Write with both halves offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dt, output logic [1:0] rs);
    logic ah;
    logic wh;
    logic bh;
    int   t;
    t = 0;
    bh = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= dt;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bh)
    begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid && bready;
      rs = bresp;
      @(posedge aclk);
      if (ah)
        awvalid <= 1'b0;
      if (wh)
        wvalid <= 1'b0;
      if (bh)
        bready <= 1'b0;
      t++;
      if (t > 100)
        tmo();
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rs);
    logic ah;
    logic rh;
    int   t;
    t = 0;
    rh = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rh)
    begin
      @(negedge aclk);
      ah = arvalid && arready;
      rh = rvalid && rready;
      dt = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ah)
        arvalid <= 1'b0;
      if (rh)
        rready <= 1'b0;
      t++;
      if (t > 100)
        tmo();
    end
  endtask

  task automatic ccmd(input logic [3:0] c, input logic [3:0] o, input logic [7:0] s);
    wr(ADDR_CTR_CMD, {16'h0, s, o, c}, r);
  endtask

  task automatic pcmd(input logic [3:0] c, input logic p, input logic [1:0] s);
    wr(ADDR_PWM_CMD, {22'h0, s, 3'h0, p, c}, r);
  endtask

  task automatic latch0(output logic [31:0] dt);
    ccmd(CC_LATCH, 4'h0, 8'h00);
    rd(ADDR_LATCH0, dt, r);
  endtask

  task automatic settle;
    repeat (2) @(negedge aclk);
  endtask

  // Counts cycles in which a port F bit is driven high
  task automatic count_hi(input int idx, input int cyc, output int c);
    c = 0;
    repeat (cyc)
    begin
      @(negedge aclk);
      if (dio_ovr.out[idx] === 1'b1)
        c++;
    end
  endtask

  initial
  begin
    err_count = 0;
    checks = 0;
    lfsr = 16'h5978;
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    dio_in = 4'hf;
    ext_gate = 2'h3;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(32'(dio_ovr), 32'h0, "pins after reset");
    chk(32'(bvalid), 32'h0, "bvalid after reset");
    rd(ADDR_STATUS, v, r);
    chk(v, 32'h0, "status after reset");
    $display("test reset done");

    repeat (4)
    begin
      lfsr = lfsr_next(lfsr);
      d = {lfsr, ~lfsr};
      wr(ADDR_DATA, d, r);
      rd(ADDR_DATA, v, r);
      chk(v, d, "data readback");
    end
    rd(8'h18, v, r);
    chk(32'(r), 32'(RESP_SLVERR), "unmapped read");
    wr(ADDR_STATUS, 32'h0, r);
    chk(32'(r), 32'(RESP_OKAY), "read-only write");
    $display("test registers done");

    lfsr = lfsr_next(lfsr);
    n = 32'h2 + 32'(lfsr[2:0]);
    wr(ADDR_DATA, n, r);
    ccmd(CC_LOAD, 4'h0, 8'h00);
    latch0(v);
    chk(v, n, "loaded count");
    ccmd(CC_DIR, 4'h1, 8'h00);
    ccmd(CC_GATE, 4'h0, 8'h00);
    ccmd(CC_CLKSRC, 4'h2, 8'h00);
    ccmd(CC_ENABLE, 4'h1, 8'h00);
    repeat (n + 10) @(negedge aclk);
    rd(ADDR_STATUS, v, r);
    chk(32'(v[0]), 32'h0, "counter stopped");
    latch0(v);
    chk(v, 32'h0, "count at zero");
    ccmd(CC_CLEAR, 4'h0, 8'h00);
    latch0(v);
    chk(v, n, "clear when down");
    ccmd(CC_AUTORL, 4'h1, 8'h00);
    ccmd(CC_OUTPUT, 4'h0, 8'h00);
    settle();
    chk(32'({dio_ovr.own[2], dio_ovr.oe[2], dio_ovr.out[2]}), 32'h6, "output pin");
    ccmd(CC_ENABLE, 4'h1, 8'h00);
    count_hi(2, 10 * n, k);
    chk(32'(k), 32'd10, "divide by n pulses");
    rd(ADDR_STATUS, v, r);
    chk(32'(v[0]), 32'h1, "counter running");
    latch0(v);
    chk(32'(v >= 1 && v <= n), 32'h1, "running latch");
    // Corner case: latch lands on the reload cycle
    @(negedge aclk);
    k = 0;
    while (dio_ovr.out[2] !== 1'b1 && k < 50)
    begin
      @(negedge aclk);
      k++;
    end
    if (k >= 50)
      tmo();
    repeat ((2 * n - 4) % n) @(posedge aclk);
    latch0(v);
    chk(v, n, "latch deferred over reload");
    $display("test counter 0 done");

    ccmd(CC_CLKSRC, 4'h0, 8'h01);
    ccmd(CC_ENABLE, 4'h1, 8'h01);
    ccmd(CC_OUTPUT, 4'h0, 8'h01);
    settle();
    chk(32'({dio_ovr.own[3], dio_ovr.oe[3]}), 32'h2, "input wins");
    ccmd(CC_RESET, 4'h0, SEL_ALL);
    settle();
    chk(32'(dio_ovr.own[3:2]), 32'h0, "pins released");
    latch0(v);
    chk(v, 32'h0, "count cleared");
    $display("test counter reset done");

    // Counter 1 up on external falling edges
    ccmd(CC_ENABLE, 4'h1, 8'h01);
    d = 32'h0;
    repeat (40)
    begin
      @(posedge aclk);
      lfsr = lfsr_next(lfsr);
      if (dio_in[3] && !lfsr[0])
        d = d + 32'h1;
      dio_in[3] <= lfsr[0];
    end
    @(posedge aclk);
    dio_in[3] <= 1'b1;
    ccmd(CC_LATCH, 4'h0, 8'h01);
    rd(ADDR_LATCH1, v, r);
    chk(v, d, "external falls counted");
    ext_gate <= 2'h1;
    ccmd(CC_GATE, 4'h1, 8'h01);
    repeat (8)
    begin
      @(posedge aclk);
      dio_in[3] <= ~dio_in[3];
    end
    ccmd(CC_LATCH, 4'h0, 8'h01);
    rd(ADDR_LATCH1, v, r);
    chk(v, d, "gate holds count");
    ext_gate <= 2'h3;
    lfsr = lfsr_next(lfsr);
    d = {16'h0, lfsr};
    wr(ADDR_DATA, d, r);
    ccmd(CC_LOAD, 4'h0, 8'h01);
    ccmd(CC_LATCH, 4'h0, 8'h01);
    rd(ADDR_LATCH1, v, r);
    chk(v, d, "counter 1 load");
    ccmd(CC_CLEAR, 4'h0, 8'h01);
    ccmd(CC_CLKSRC, 4'h3, 8'h01);
    // Window of four slow periods from the clock switch to the latch
    repeat (4 * SLOW_DIV - 3) @(negedge aclk);
    ccmd(CC_LATCH, 4'h0, 8'h01);
    rd(ADDR_LATCH1, v, r);
    chk(v, 32'd4, "clear up then slow ticks");
    $display("test counter 1 done");

    wr(ADDR_DATA, 32'd10, r);
    pcmd(PC_LOAD, 1'b0, 2'h0);
    wr(ADDR_DATA, 32'd3, r);
    pcmd(PC_LOAD, 1'b1, 2'h0);
    pcmd(PC_CLKSRC, 1'b0, 2'h0);
    pcmd(PC_POL, 1'b1, 2'h0);
    pcmd(PC_ROUTE, 1'b1, 2'h0);
    settle();
    chk(32'({dio_ovr.own[0], dio_ovr.oe[0], dio_ovr.out[0]}), 32'h7,
        "pwm idle low pulse");
    pcmd(PC_POL, 1'b0, 2'h0);
    settle();
    chk(32'(dio_ovr.out[0]), 32'h0, "pwm idle high pulse");
    pcmd(PC_PULSE, 1'b1, 2'h0);
    pcmd(PC_START, 1'b0, 2'h0);
    rd(ADDR_STATUS, v, r);
    chk(32'(v[8]), 32'h1, "pwm running");
    count_hi(0, 100, k);
    chk(32'(k), 32'd30, "pwm duty");
    pcmd(PC_STOP, 1'b0, 2'h0);
    settle();
    chk(32'(dio_ovr.out[0]), 32'h0, "pwm stopped level");
    rd(ADDR_STATUS, v, r);
    chk(32'(v[8]), 32'h0, "pwm stopped");
    pcmd(PC_RESET, 1'b0, 2'h0);
    settle();
    chk(32'(dio_ovr.own[0]), 32'h0, "pwm pin released");
    $display("test pwm done");
    end_sim();
  end
endmodule
`default_nettype wire
